// ==== common/data_space_pkg.sv ====
package data_space_pkg;

  // address and data geometry
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned WORD_ADDR_W = 15;

  // default map: implemented ram and the y block inside it
  localparam logic [15:0] IMPL_LO_DEF = 16'h0000;
  localparam logic [15:0] IMPL_HI_DEF = 16'h27FF;
  localparam logic [15:0] Y_LO_DEF    = 16'h1800;
  localparam logic [15:0] Y_HI_DEF    = 16'h27FF;

  // pointer step per operand size
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // pointer register selector for the dual operand fetch
  localparam logic [1:0] PTR_XA = 2'h0;
  localparam logic [1:0] PTR_XB = 2'h1;
  localparam logic [1:0] PTR_YA = 2'h2;
  localparam logic [1:0] PTR_YB = 2'h3;

endpackage : data_space_pkg

// ==== rtl/data_space_byte_word_access.sv ====
// Functional notes
// - reads of unimplemented addresses return zero
// - dual-operand fetch via x pointers into y block returns zero
// - dual-operand fetch via y pointers into x space returns zero
// - effective addresses are 16-bit byte addresses, 64 Kbytes, 32K words
// - 16-bit datapath, memory as 16-bit words with addressable bytes
// - byte read fetches whole word, address lsb picks the byte
// - selected byte appears on low byte of x read data
// - y read path fetches words only
// - shared word decode, separate per-lane write strobes
// - post-increment steps 1 for bytes, 2 for words
// - y path is read only; all writes go over x write path
// - dual-operand reads x and y spaces concurrently via own pointers
`timescale 1ns/1ps
module data_space_byte_word_access #(
  parameter logic [15:0] IMPL_LO = data_space_pkg::IMPL_LO_DEF,
  parameter logic [15:0] IMPL_HI = data_space_pkg::IMPL_HI_DEF,
  parameter logic [15:0] Y_LO    = data_space_pkg::Y_LO_DEF,
  parameter logic [15:0] Y_HI    = data_space_pkg::Y_HI_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // x read request
  input  wire logic        x_rd_req,
  input  wire logic [15:0] x_rd_addr,
  input  wire logic        x_rd_byte,
  input  wire logic        dual_operand_multiply_class,
  input  wire logic        x_rd_ptr_sel,
  // y read request, words only
  input  wire logic        y_rd_req,
  input  wire logic [15:0] y_rd_addr,
  input  wire logic        y_rd_ptr_sel,
  // x write request
  input  wire logic        x_wr_req,
  input  wire logic [15:0] x_wr_addr,
  input  wire logic        x_wr_byte,
  input  wire logic [15:0] x_wr_data,
  // post increment helper
  input  wire logic [15:0] source_pointer_register,
  input  wire logic        ptr_byte_op,
  // answers
  output logic      [15:0] x_rd_data,
  output logic             x_rd_valid,
  output logic      [15:0] y_rd_data,
  output logic             y_rd_valid,
  output logic      [15:0] ptr_next
);

  localparam int unsigned DEPTH = 1 << data_space_pkg::WORD_ADDR_W;

  // two byte lanes with one word decode
  logic [7:0] lane_lo [DEPTH];
  logic [7:0] lane_hi [DEPTH];

  typedef struct packed {
    logic [15:0] x_data;
    logic        x_valid;
    logic [15:0] y_data;
    logic        y_valid;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic [14:0] x_word;
  logic [14:0] y_word;
  logic [14:0] w_word;
  logic        x_impl;
  logic        y_impl;
  logic        x_in_y;
  logic        y_in_y;
  logic        x_bad;
  logic        y_bad;
  logic        wr_lo;
  logic        wr_hi;
  logic [15:0] x_word_data;
  logic [15:0] y_word_data;

  // word index drops the byte bit
  assign x_word = x_rd_addr[15:1];
  assign y_word = y_rd_addr[15:1];
  assign w_word = x_wr_addr[15:1];

  // map decode
  assign x_impl = (x_rd_addr >= IMPL_LO) && (x_rd_addr <= IMPL_HI);
  assign y_impl = (y_rd_addr >= IMPL_LO) && (y_rd_addr <= IMPL_HI);
  assign x_in_y = (x_rd_addr >= Y_LO) && (x_rd_addr <= Y_HI);
  assign y_in_y = (y_rd_addr >= Y_LO) && (y_rd_addr <= Y_HI);

  // x pointer into the y block during a dual fetch is refused
  assign x_bad = !x_impl || (dual_operand_multiply_class && x_in_y);
  // y path only reaches the y block
  assign y_bad = !y_impl || !y_in_y;

  // per-lane strobes; a word write hits both lanes
  assign wr_lo = x_wr_req && (!x_wr_byte || !x_wr_addr[0]);
  assign wr_hi = x_wr_req && (!x_wr_byte ||  x_wr_addr[0]);

  // the array is only written through the x write port; y never writes
  always_ff @(posedge clk_sys) begin
    if (wr_lo) begin
      lane_lo[w_word] <= x_wr_data[7:0];
    end
    if (wr_hi) begin
      lane_hi[w_word] <= x_wr_byte ? x_wr_data[7:0]
                                   : x_wr_data[15:8];
    end
  end

  // combinational word fetch; registered answer one cycle later
  assign x_word_data = {lane_hi[x_word], lane_lo[x_word]};
  assign y_word_data = {lane_hi[y_word], lane_lo[y_word]};

  always_comb begin
    st_nxt         = st_r;
    st_nxt.x_valid = x_rd_req;
    st_nxt.y_valid = y_rd_req && dual_operand_multiply_class;
    if (x_rd_req) begin
      if (x_bad) begin
        st_nxt.x_data = data_space_pkg::ZERO_WORD;
      end else if (x_rd_byte) begin
        // chosen byte goes to the low byte, upper byte zero
        st_nxt.x_data = {8'h00, x_rd_addr[0] ? x_word_data[15:8]
                                             : x_word_data[7:0]};
      end else begin
        st_nxt.x_data = x_word_data;
      end
    end
    if (y_rd_req) begin
      st_nxt.y_data = y_bad ? data_space_pkg::ZERO_WORD
                            : y_word_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign x_rd_data  = st_r.x_data;
  assign x_rd_valid = st_r.x_valid;
  assign y_rd_data  = st_r.y_data;
  assign y_rd_valid = st_r.y_valid;

  // size-scaled post increment, purely combinational
  assign ptr_next = source_pointer_register +
                    (ptr_byte_op ? data_space_pkg::STEP_BYTE
                                 : data_space_pkg::STEP_WORD);

  // selectors kept for the agu; they only name the pointer in use
  logic unused_sel;
  assign unused_sel = x_rd_ptr_sel ^ y_rd_ptr_sel;

  // checks; the zero-read checks take map bounds from the parameters, the byte lane and word read checks gate on x_bad, the write checks do not
  unimpl_zero_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_rd_req && !((x_rd_addr >= IMPL_LO) && (x_rd_addr <= IMPL_HI))
    |=> x_rd_data == 16'h0000 && x_rd_valid)
    else $error("unimplemented read not zero");

  xptr_yblock_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_rd_req && dual_operand_multiply_class
    && (x_rd_addr >= Y_LO) && (x_rd_addr <= Y_HI)
    |=> x_rd_data == 16'h0000)
    else $error("x pointer into y block not zero");

  yptr_xspace_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    y_rd_req && !((y_rd_addr >= Y_LO) && (y_rd_addr <= Y_HI))
    |=> y_rd_data == 16'h0000)
    else $error("y pointer into x space not zero");

  // y path only answers the dual operand prefetch
  y_dual_only_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    y_rd_req && !dual_operand_multiply_class |=> !y_rd_valid)
    else $error("y answered outside a dual fetch");

  byte_upper_zero_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_rd_req && x_rd_byte |=> x_rd_data[15:8] == 8'h00)
    else $error("byte read upper byte not zero");

  byte_lane_sel_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_rd_req && x_rd_byte && !x_bad
    |=> x_rd_data[7:0] == ($past(x_rd_addr[0]) ? $past(x_word_data[15:8])
                                               : $past(x_word_data[7:0])))
    else $error("byte read picked wrong lane");

  byte_strobe_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_wr_req && x_wr_byte |-> (wr_lo != wr_hi) && (wr_hi == x_wr_addr[0]))
    else $error("byte write strobes wrong lane");

  word_strobe_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_wr_req && !x_wr_byte |-> wr_lo && wr_hi)
    else $error("word write missed a lane");

  // landed contents; case equality so a never-written lane still compares
  even_byte_lane_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_wr_req && x_wr_byte && !x_wr_addr[0]
    |=> lane_lo[$past(w_word)] == $past(x_wr_data[7:0])
        && lane_hi[$past(w_word)] === $past(lane_hi[w_word]))
    else $error("even byte write hit wrong lane");

  odd_byte_lane_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_wr_req && x_wr_byte && x_wr_addr[0]
    |=> lane_hi[$past(w_word)] == $past(x_wr_data[7:0])
        && lane_lo[$past(w_word)] === $past(lane_lo[w_word]))
    else $error("odd byte write hit wrong lane");

  word_lands_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_wr_req && !x_wr_byte
    |=> {lane_hi[$past(w_word)], lane_lo[$past(w_word)]} == $past(x_wr_data))
    else $error("word write did not land");

  ptr_step_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    ptr_next - source_pointer_register == (ptr_byte_op ? 16'h0001
                                                       : 16'h0002))
    else $error("pointer step wrong");

  word_align_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    x_rd_req && !x_rd_byte && !x_bad
    |=> x_rd_data == $past(x_word_data))
    else $error("word read not aligned word");

  cov_byte_rd_c: cover property (@(posedge clk_sys) x_rd_req && x_rd_byte);
  cov_dual_c: cover property (@(posedge clk_sys)
    x_rd_req && y_rd_req && dual_operand_multiply_class);
  cov_byte_wr_c: cover property (@(posedge clk_sys) x_wr_req && x_wr_byte);
  cov_bad_x_c: cover property (@(posedge clk_sys) x_rd_req && x_bad);

endmodule : data_space_byte_word_access

// ==== verif/core_agu_model.sv ====
`timescale 1ns/1ps
// core side: requests change 1 ns after an edge, held through one edge
module core_agu_model (
  input  wire logic        clk_sys,
  output logic             x_rd_req,
  output logic      [15:0] x_rd_addr,
  output logic             x_rd_byte,
  output logic             dual_operand_multiply_class,
  output logic             y_rd_req,
  output logic      [15:0] y_rd_addr,
  output logic             x_wr_req,
  output logic      [15:0] x_wr_addr,
  output logic             x_wr_byte,
  output logic      [15:0] x_wr_data,
  output logic      [15:0] source_pointer_register,
  output logic             ptr_byte_op
);
  initial begin
    {x_rd_req, y_rd_req, x_wr_req, x_rd_byte, x_wr_byte} = 5'h00;
    {dual_operand_multiply_class, ptr_byte_op} = 2'h0;
    {x_rd_addr, y_rd_addr, x_wr_addr} = 48'h0;
    {x_wr_data, source_pointer_register} = 32'h0;
  end
  // released buses show the inverse so stale values never pass
  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    {x_wr_req, x_wr_addr, x_wr_byte, x_wr_data} = {1'b1, a, b, d};
    @(posedge clk_sys);
    #1;
    {x_wr_req, x_wr_addr, x_wr_data} = {1'b0, ~a, ~d};
  endtask : wr
  // y side has no size pin: words only
  task automatic rd(input logic xe, input logic [15:0] xa, input logic xb,
                    input logic dl, input logic ye, input logic [15:0] ya);
    @(posedge clk_sys);
    #1;
    {x_rd_req, x_rd_addr, x_rd_byte} = {xe, xa, xb};
    {dual_operand_multiply_class, y_rd_req, y_rd_addr} = {dl, ye, ya};
    @(posedge clk_sys);
    #1;
    {x_rd_req, y_rd_req, x_rd_addr, y_rd_addr} = {2'h0, ~xa, ~ya};
    dual_operand_multiply_class = 1'b0;
  endtask : rd
  task automatic ptr(input logic [15:0] p, input logic b);
    @(posedge clk_sys);
    #1;
    {source_pointer_register, ptr_byte_op} = {p, b};
    #1;
  endtask : ptr
endmodule : core_agu_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        x_rd_req, x_rd_byte, dual_operand_multiply_class, y_rd_req;
  logic        x_wr_req, x_wr_byte, ptr_byte_op, x_rd_valid, y_rd_valid;
  logic [15:0] x_rd_addr, y_rd_addr, x_wr_addr, x_wr_data;
  logic [15:0] source_pointer_register, x_rd_data, y_rd_data, ptr_next;
  int          fail_count  = 0;
  int          check_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  core_agu_model agu (.clk_sys, .x_rd_req, .x_rd_addr, .x_rd_byte,
    .dual_operand_multiply_class, .y_rd_req, .y_rd_addr, .x_wr_req,
    .x_wr_addr, .x_wr_byte, .x_wr_data, .source_pointer_register,
    .ptr_byte_op);
  // pointer selectors are unused by the design
  data_space_byte_word_access dut (.clk_sys, .rst, .x_rd_req, .x_rd_addr,
    .x_rd_byte, .dual_operand_multiply_class, .x_rd_ptr_sel(1'b0),
    .y_rd_req, .y_rd_addr, .y_rd_ptr_sel(1'b1), .x_wr_req, .x_wr_addr,
    .x_wr_byte, .x_wr_data, .source_pointer_register, .ptr_byte_op,
    .x_rd_data, .x_rd_valid, .y_rd_data, .y_rd_valid, .ptr_next);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // plain x read, answer registered on the taking edge and checked 1 ns after it
  task automatic xr(input logic [15:0] a, input logic b, input logic [15:0] e);
    agu.rd(1'b1, a, b, 1'b0, 1'b0, 16'h0000);
    check({15'h0, x_rd_valid}, 16'h0001);
    check(x_rd_data, e);
  endtask : xr

  // upper byte of byte-write data is junk to catch a wrong lane
  task automatic test_lanes();
    agu.wr(16'h0100, 1'b0, 16'h1234);
    agu.wr(16'h0101, 1'b1, 16'hFFAB);
    xr(16'h0101, 1'b0, 16'hAB34);
    xr(16'h0101, 1'b1, 16'h00AB);
    xr(16'h0100, 1'b1, 16'h0034);
    agu.wr(16'h0100, 1'b1, 16'hEE77);
    xr(16'h0100, 1'b0, 16'hAB77);
    $display("test_lanes done");
  endtask : test_lanes

  task automatic test_unimpl();
    agu.wr(16'h27FE, 1'b0, 16'hC3A5);
    xr(16'h27FE, 1'b0, 16'hC3A5);
    agu.wr(16'h2800, 1'b0, 16'h5555);
    xr(16'h2800, 1'b0, 16'h0000);
    xr(16'hFFFF, 1'b1, 16'h0000);
    $display("test_unimpl done");
  endtask : test_unimpl

  task automatic test_dual();
    agu.wr(16'h1800, 1'b0, 16'h0BEE);
    xr(16'h1800, 1'b0, 16'h0BEE);
    agu.rd(1'b1, 16'h1800, 1'b0, 1'b1, 1'b1, 16'h0100);
    check(x_rd_data, 16'h0000);
    check({15'h0, y_rd_valid}, 16'h0001);
    check(y_rd_data, 16'h0000);
    agu.rd(1'b1, 16'h0100, 1'b0, 1'b1, 1'b1, 16'h1801);
    check(x_rd_data, 16'hAB77);
    check(y_rd_data, 16'h0BEE);
    agu.rd(1'b0, 16'h0000, 1'b0, 1'b0, 1'b1, 16'h1800);
    check({15'h0, y_rd_valid}, 16'h0000);
    $display("test_dual done");
  endtask : test_dual

  task automatic test_ptr();
    agu.ptr(16'h00FF, 1'b1);
    check(ptr_next, 16'h0100);
    agu.ptr(16'h00FF, 1'b0);
    check(ptr_next, 16'h0101);
    agu.ptr(16'hFFFE, 1'b0);
    check(ptr_next, 16'h0000);
    $display("test_ptr done");
  endtask : test_ptr

  // mid-run reset clears the answers but leaves the array contents
  task automatic test_reset();
    agu.rd(1'b1, 16'h0100, 1'b0, 1'b0, 1'b0, 16'h0000);
    check(x_rd_data, 16'hAB77);
    rst = 1'b1;
    @(posedge clk_sys);
    #1 rst = 1'b0;
    check(x_rd_data, 16'h0000);
    check({15'h0, x_rd_valid}, 16'h0000);
    xr(16'h0100, 1'b0, 16'hAB77);
    $display("test_reset done");
  endtask : test_reset

  // hang guard
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    check({15'h0, x_rd_valid}, 16'h0000);
    test_lanes();
    test_unimpl();
    test_dual();
    test_ptr();
    test_reset();
    stop_test();
  end
endmodule : tb
